//--- verilog/ddr3_cmd_consts.svh
`ifndef DDR3_CMD_CONSTS_SVH
`define DDR3_CMD_CONSTS_SVH

// Mode register select on the bank pins
`define MR_SEL_MR0      3'h0
`define MR_SEL_MR3      3'h3
`define MR_RESET        14'h0000

// Mode register 0 burst length field
`define MR0_BL_LSB      0
`define BL_FIXED8       2'h0
`define BL_OTF          2'h1
`define BL_FIXED4       2'h2

// Mode register 3 fields
`define MR3_MPR_EN_BIT  2
`define MR3_LOC_LSB     0
`define MPR_LOC_PATTERN 2'h0

// Address bits with command meaning
`define ADDR_AP_BIT     10
`define ADDR_BC_BIT     12
`define ADDR_NIBBLE_BIT 2

// Burst shaping; burst position 0 is the LSB
`define MPR_PATTERN     8'hAA
`define MPR_RFU_DATA    8'h00
`define BL8_BEATS       4'h8
`define BC4_BEATS       4'h4
`define NIBBLE_LO_START 3'h0
`define NIBBLE_HI_START 3'h4

`endif

//--- verilog/ddr3_cmd_pkg.sv
package ddr3_cmd_pkg;

  typedef enum logic [3:0] {
    cmd_none       = 4'h0,
    cmd_mrs        = 4'h1,
    cmd_refresh    = 4'h2,
    cmd_activate   = 4'h3,
    cmd_precharge  = 4'h4,
    cmd_prech_all  = 4'h5,
    cmd_read       = 4'h6,
    cmd_write      = 4'h7,
    cmd_zq_long    = 4'h8,
    cmd_zq_short   = 4'h9,
    cmd_nop        = 4'hA,
    cmd_deselect   = 4'hB,
    cmd_sr_entry   = 4'hC,
    cmd_sr_exit    = 4'hD,
    cmd_pd_entry   = 4'hE,
    cmd_pd_exit    = 4'hF
  } cmd_e;

  typedef enum logic [2:0] {
    st_active       = 3'b001,
    st_power_down   = 3'b010,
    st_self_refresh = 3'b100
  } power_state_e;

endpackage : ddr3_cmd_pkg

//--- verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int width = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Asynchronous pins and their synchronised copy
  input  wire logic [width-1:0] pins,
  output logic      [width-1:0] pins_sync
);

  logic [width-1:0] meta;

  initial begin
    if (width < 1) $error("pin_sync: width must be at least 1");
  end

  // Two stages; the first is read only by the second
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta      <= '0;
      pins_sync <= '0;
    end else begin
      meta      <= pins;
      pins_sync <= meta;
    end
  end

endmodule : pin_sync

//--- verilog/mpr_burst.sv
`timescale 1ns/1ns
`include "ddr3_cmd_consts.svh"
module mpr_burst (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Burst request
  input  wire logic       start,
  input  wire logic       chop,
  input  wire logic       nibble_hi,
  input  wire logic [7:0] source,
  // Beat timing
  input  wire logic       beat_tick,
  // Beat output
  output logic            active,
  output logic            beat_bit,
  output logic [2:0]      beat_idx
);

  logic [7:0] source_q;
  logic [3:0] remaining;

  // Start position, length and stepping of the burst
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active    <= 1'b0;
      beat_idx  <= 3'h0;
      remaining <= 4'h0;
      source_q  <= 8'h00;
    end else if (start) begin
      active    <= 1'b1;
      source_q  <= source;
      remaining <= chop ? `BC4_BEATS : `BL8_BEATS;
      beat_idx  <= (chop && nibble_hi) ? `NIBBLE_HI_START : `NIBBLE_LO_START;
    end else if (active && beat_tick) begin
      beat_idx  <= beat_idx + 3'h1;
      remaining <= remaining - 4'h1;
      if (remaining == 4'h1) begin
        active <= 1'b0;
      end
    end
  end

  // Burst position 0 is the LSB, position 7 the MSB
  assign beat_bit = source_q[beat_idx];

endmodule : mpr_burst

//--- verilog/ddr3_cmd_mpr.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "ddr3_cmd_consts.svh"
module ddr3_cmd_mpr #(
  parameter int  read_latency = 5,
  parameter bit  mpr_repeat   = 1'b1
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // Memory command pins
  input  wire logic                mem_ck,
  input  wire logic                cke,
  input  wire logic                cs_n,
  input  wire logic                ras_n,
  input  wire logic                cas_n,
  input  wire logic                we_n,
  input  wire logic [2:0]          ba,
  input  wire logic [13:0]         addr,
  // Data pins
  output logic      [7:0]          low_byte_lane,
  output logic      [7:0]          high_byte_lane,
  output logic                     dq_oe,
  // Decoded command
  output ddr3_cmd_pkg::cmd_e       cmd,
  output logic                     cmd_valid,
  // Array access
  output logic                     array_rd,
  output logic                     array_wr,
  output logic [2:0]               array_bank,
  output logic [13:0]              array_addr,
  output logic                     array_auto_pre,
  output logic                     array_chop,
  output logic [2:0]               array_beat,
  input  wire logic [15:0]         array_rd_data,
  // Mode and power state
  output logic                     mpr_mode,
  output logic                     power_down,
  output logic                     self_refresh
);
  import ddr3_cmd_pkg::*;

  localparam int lat_w = 8;

  initial begin
    if (read_latency < 1 || read_latency > 255) $error("ddr3_cmd_mpr: read_latency out of range");
  end

  // Command from strobe levels with CKE high on both edges
  function automatic cmd_e decode_strobes(input logic c_n, input logic r_n, input logic a_n,
                                          input logic w_n, input logic a10);
    if (c_n) begin
      decode_strobes = cmd_deselect;
    end else begin
      unique case ({r_n, a_n, w_n})
        3'b000:  decode_strobes = cmd_mrs;
        3'b001:  decode_strobes = cmd_refresh;
        3'b011:  decode_strobes = cmd_activate;
        3'b010:  decode_strobes = a10 ? cmd_prech_all : cmd_precharge;
        3'b101:  decode_strobes = cmd_read;
        3'b100:  decode_strobes = cmd_write;
        3'b110:  decode_strobes = a10 ? cmd_zq_long : cmd_zq_short;
        3'b111:  decode_strobes = cmd_nop;
      endcase
    end
  endfunction : decode_strobes

  // Chop selection from the burst field and bit 12
  function automatic logic chop_select(input logic [1:0] bl, input logic a12);
    if (bl == `BL_OTF) begin
      chop_select = ~a12;
    end else begin
      chop_select = (bl == `BL_FIXED4);
    end
  endfunction : chop_select

  // Synchronised pins
  logic [22:0] pins_s;
  logic        ck_s;
  logic        ck_d;
  logic        cke_s;
  logic        cs_n_s;
  logic        ras_n_s;
  logic        cas_n_s;
  logic        we_n_s;
  logic [2:0]  ba_s;
  logic [13:0] addr_s;
  logic        ck_rise;
  logic        beat_tick;

  pin_sync #(
    .width     (23)
  ) u_pin_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pins      ({mem_ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
    .pins_sync (pins_s)
  );

  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s} = pins_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ck_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
    end
  end

  // Commands sampled on the rising memory clock edge
  assign ck_rise   = ck_s & ~ck_d;
  assign beat_tick = ck_s ^ ck_d;

  // Command decode including CKE transitions
  logic        cke_prev;
  cmd_e        next_cmd;
  cmd_e        strobe_cmd;

  assign strobe_cmd = decode_strobes(cs_n_s, ras_n_s, cas_n_s, we_n_s, addr_s[`ADDR_AP_BIT]);

  always_comb begin
    next_cmd = cmd_none;
    if (cke_prev && cke_s) begin
      next_cmd = strobe_cmd;
    end else if (cke_prev && !cke_s) begin
      if (strobe_cmd == cmd_refresh) begin
        next_cmd = cmd_sr_entry;
      end else if (strobe_cmd == cmd_nop || strobe_cmd == cmd_deselect) begin
        next_cmd = cmd_pd_entry;
      end
    end else if (!cke_prev && cke_s) begin
      if (self_refresh && cs_n_s) begin
        next_cmd = cmd_sr_exit;
      end else if (power_down && (strobe_cmd == cmd_nop || strobe_cmd == cmd_deselect)) begin
        next_cmd = cmd_pd_exit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cke_prev  <= 1'b0;
      cmd       <= cmd_none;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (ck_rise) begin
        cke_prev  <= cke_s;
        cmd       <= next_cmd;
        cmd_valid <= (next_cmd != cmd_none);
      end
    end
  end

  // Mode registers
  logic [1:0] burst_len;
  logic [1:0] mpr_loc;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burst_len <= `BL_FIXED8;
      mpr_loc   <= `MPR_LOC_PATTERN;
      mpr_mode  <= 1'b0;
    end else if (ck_rise && next_cmd == cmd_mrs) begin
      if (ba_s == `MR_SEL_MR0) begin
        burst_len <= addr_s[`MR0_BL_LSB +: 2];
      end
      if (ba_s == `MR_SEL_MR3) begin
        mpr_mode <= addr_s[`MR3_MPR_EN_BIT];
        mpr_loc  <= addr_s[`MR3_LOC_LSB +: 2];
      end
    end
  end

  // Power state
  power_state_e pstate;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pstate <= st_active;
    end else if (ck_rise) begin
      unique case (pstate)
        st_active: begin
          if (next_cmd == cmd_sr_entry) begin
            pstate <= st_self_refresh;
          end else if (next_cmd == cmd_pd_entry) begin
            pstate <= st_power_down;
          end
        end
        st_power_down: begin
          if (next_cmd == cmd_pd_exit) begin
            pstate <= st_active;
          end
        end
        st_self_refresh: begin
          if (next_cmd == cmd_sr_exit) begin
            pstate <= st_active;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_down   <= 1'b0;
      self_refresh <= 1'b0;
    end else begin
      power_down   <= (pstate == st_power_down);
      self_refresh <= (pstate == st_self_refresh);
    end
  end

  // Array requests; MPR mode keeps reads and writes off the array
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      array_rd       <= 1'b0;
      array_wr       <= 1'b0;
      array_bank     <= 3'h0;
      array_addr     <= 14'h0000;
      array_auto_pre <= 1'b0;
      array_chop     <= 1'b0;
    end else begin
      array_rd <= 1'b0;
      array_wr <= 1'b0;
      if (ck_rise && !mpr_mode) begin
        if (next_cmd == cmd_read || next_cmd == cmd_write || next_cmd == cmd_activate) begin
          array_bank <= ba_s;
          array_addr <= addr_s;
        end
        if (next_cmd == cmd_read || next_cmd == cmd_write) begin
          array_rd       <= (next_cmd == cmd_read);
          array_wr       <= (next_cmd == cmd_write);
          array_auto_pre <= addr_s[`ADDR_AP_BIT];
          array_chop     <= chop_select(burst_len, addr_s[`ADDR_BC_BIT]);
        end
      end
    end
  end

  // Read latency, the same count for MPR and array reads
  logic [lat_w-1:0] lat_cnt;
  logic             lat_pend;
  logic             rd_chop;
  logic             rd_nibble_hi;
  logic             rd_from_mpr;
  logic             burst_start;

  assign burst_start = lat_pend && ck_rise && (lat_cnt == lat_w'(1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_cnt      <= '0;
      lat_pend     <= 1'b0;
      rd_chop      <= 1'b0;
      rd_nibble_hi <= 1'b0;
      rd_from_mpr  <= 1'b0;
    end else if (ck_rise && next_cmd == cmd_read) begin
      lat_cnt      <= lat_w'(read_latency);
      lat_pend     <= 1'b1;
      rd_from_mpr  <= mpr_mode;
      rd_chop      <= chop_select(burst_len, addr_s[`ADDR_BC_BIT]);
      rd_nibble_hi <= addr_s[`ADDR_NIBBLE_BIT];
    end else if (ck_rise && lat_pend) begin
      lat_cnt <= lat_cnt - lat_w'(1);
      if (lat_cnt == lat_w'(1)) begin
        lat_pend <= 1'b0;
      end
    end
  end

  // MPR source by location; reserved locations read as a fixed word
  logic [7:0] mpr_source;

  assign mpr_source = (mpr_loc == `MPR_LOC_PATTERN) ? `MPR_PATTERN : `MPR_RFU_DATA;

  logic       burst_active;
  logic       burst_bit;
  logic [2:0] burst_idx;

  mpr_burst u_mpr_burst (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .start     (burst_start),
    .chop      (rd_chop),
    .nibble_hi (rd_nibble_hi),
    .source    (mpr_source),
    .beat_tick (beat_tick),
    .active    (burst_active),
    .beat_bit  (burst_bit),
    .beat_idx  (burst_idx)
  );

  // Data pins, one beat per memory clock edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_byte_lane  <= 8'h00;
      high_byte_lane <= 8'h00;
      dq_oe          <= 1'b0;
      array_beat     <= 3'h0;
    end else if (burst_active && beat_tick) begin
      dq_oe      <= 1'b1;
      array_beat <= burst_idx;
      if (rd_from_mpr) begin
        low_byte_lane  <= {(mpr_repeat ? {7{burst_bit}} : 7'h00), burst_bit};
        high_byte_lane <= {(mpr_repeat ? {7{burst_bit}} : 7'h00), burst_bit};
      end else begin
        low_byte_lane  <= array_rd_data[7:0];
        high_byte_lane <= array_rd_data[15:8];
      end
    end else if (!burst_active && beat_tick) begin
      dq_oe          <= 1'b0;
      low_byte_lane  <= 8'h00;
      high_byte_lane <= 8'h00;
    end
  end

endmodule : ddr3_cmd_mpr

//--- testbench/ddr3_cmd_mpr_monitor.sv
`timescale 1ns/1ns
module ddr3_cmd_mpr_monitor
  import ddr3_cmd_pkg::*;
#(
  parameter bit mpr_repeat = 1'b1
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Data pins
  input wire logic [7:0]         low_byte_lane,
  input wire logic [7:0]         high_byte_lane,
  input wire logic               dq_oe,
  // Decode and state
  input wire ddr3_cmd_pkg::cmd_e cmd,
  input wire logic               cmd_valid,
  input wire logic               array_rd,
  input wire logic               array_wr,
  input wire logic               array_auto_pre,
  input wire logic               mpr_mode,
  input wire logic               power_down,
  input wire logic               self_refresh
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] run_len;
  // Cycles the data pins have been driven
  always_ff @(posedge clk) begin
    if (sys_rst || !dq_oe) begin
      run_len <= 8'h00;
    end else begin
      run_len <= run_len + 8'h01;
    end
  end
  sequence pd_req;
    cmd_valid && cmd == cmd_pd_entry;
  endsequence
  sequence sr_req;
    cmd_valid && cmd == cmd_sr_entry;
  endsequence
  rd_gate_a: assert property (array_rd |-> !mpr_mode) else $error("array read in mpr mode");
  rd_decode_a: assert property (array_rd == (cmd_valid && cmd == cmd_read && !mpr_mode))
    else $error("array read does not match decoded read");
  wr_decode_a: assert property (array_wr == (cmd_valid && cmd == cmd_write && !mpr_mode))
    else $error("array write does not match decoded write");
  valid_pulse_a: assert property (cmd_valid |-> cmd != cmd_none ##1 !cmd_valid) else $error("bad cmd pulse");
  mpr_lanes_a: assert property (dq_oe && mpr_mode |-> high_byte_lane == low_byte_lane &&
    (mpr_repeat ? low_byte_lane inside {8'h00, 8'hFF} : low_byte_lane[7:1] == 7'h00)) else $error("bad mpr lanes");
  idle_lanes_a: assert property (!dq_oe |-> {high_byte_lane, low_byte_lane} == 16'h0000)
    else $error("idle lanes");
  rda_plain_a: assert property (mpr_mode && cmd_valid && cmd == cmd_read |->
    $stable(array_auto_pre) ##1 $stable(array_auto_pre)) else $error("mpr read touched precharge");
  pd_entry_a: assert property (pd_req |-> ##[1:2] power_down) else $error("power down not entered");
  sr_entry_a: assert property (sr_req |-> ##[1:2] self_refresh) else $error("self refresh not entered");
  burst_len_a: assert property ($fell(dq_oe) |-> run_len inside {[23:27], [48:52]})
    else $error("burst length");
endmodule : ddr3_cmd_mpr_monitor
bind ddr3_cmd_mpr ddr3_cmd_mpr_monitor #(.mpr_repeat(mpr_repeat)) mon (.clk, .sys_rst, .low_byte_lane,
  .high_byte_lane, .dq_oe, .cmd, .cmd_valid, .array_rd, .array_wr, .array_auto_pre, .mpr_mode, .power_down,
  .self_refresh);

//--- testbench/ddr3_ctl_model.sv
`timescale 1ns/1ns
module ddr3_ctl_model (
  // Command pins
  output logic        mem_ck,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr,
  // Read capture
  input wire logic [7:0] low_byte_lane,
  input wire logic [7:0] high_byte_lane,
  input wire logic       dq_oe
);
  logic [15:0] q[$];
  initial begin
    mem_ck = 1'b0;
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    ba = 3'h0;
    addr = 14'h0000;
  end
  // Pins move only with the clock low, well away from the rise
  task automatic send(input logic [4:0] c, input logic [2:0] b, input logic [13:0] a);
    {cke, cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    #60 mem_ck = 1'b1;
    #65 mem_ck = 1'b0;
  endtask : send
  // Capture each beat 45 ns after each memory clock edge
  always @(mem_ck) begin
    #45;
    if (dq_oe === 1'b1) begin
      q.push_back({high_byte_lane, low_byte_lane});
    end
  end
endmodule : ddr3_ctl_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import ddr3_cmd_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        mem_ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe, cmd_valid, array_rd, array_wr;
  logic        array_auto_pre, array_chop, mpr_mode, power_down, self_refresh;
  logic [2:0]  ba, array_bank, array_beat;
  logic [13:0] addr, array_addr;
  logic [7:0]  low_byte_lane, high_byte_lane;
  logic [15:0] array_rd_data = 16'h0000;
  cmd_e        cmd;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [4:0]  tc[10] = '{5'h10, 5'h11, 5'h13, 5'h12, 5'h12, 5'h16, 5'h16, 5'h17, 5'h1F, 5'h14};
  logic [13:0] ta[10] = '{14'h0, 14'h0, 14'h1234, 14'h0, 14'h0400, 14'h0400, 14'h0, 14'h0, 14'h0, 14'h0408};
  cmd_e        te[10] = '{cmd_mrs, cmd_refresh, cmd_activate, cmd_precharge, cmd_prech_all,
                          cmd_zq_long, cmd_zq_short, cmd_nop, cmd_deselect, cmd_write};
  always #5 clk = ~clk;
  always @(posedge clk) array_rd_data <= {8'hA5, 5'h00, array_beat};
  ddr3_cmd_mpr #(.read_latency(2)) uut (.clk, .sys_rst, .mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .low_byte_lane, .high_byte_lane, .dq_oe, .cmd, .cmd_valid, .array_rd, .array_wr, .array_bank,
    .array_addr, .array_auto_pre, .array_chop, .array_beat, .array_rd_data, .mpr_mode, .power_down,
    .self_refresh);
  ddr3_ctl_model ctl (.mem_ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .low_byte_lane,
    .high_byte_lane, .dq_oe);
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Read, then clock out the burst with NOPs and compare every beat
  task automatic burst(input logic [13:0] a, input logic [7:0] src, input int n, input int pos, input bit arr);
    logic [15:0] m;
    m = arr ? 16'hFF00 : 16'hFFFF;
    ctl.q.delete();
    ctl.send(5'h15, 3'h7, a);
    check("read cmd", cmd, cmd_read);
    repeat (8) ctl.send(5'h17, 3'h0, 14'h0000);
    check("beats", ctl.q.size(), n);
    for (int k = 0; k < n; k++) begin
      check("beat", ctl.q[k] & m, (arr ? 16'hA500 : {16{src[pos + k]}}) & m);
    end
  endtask : burst
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Memory clock starts once the pin synchronisers are clear; DLL taken as locked
    repeat (4) @(posedge clk);
    #2;
    ctl.send(5'h17, 3'h0, 14'h0000);
    for (int i = 0; i < 10; i++) begin
      ctl.send(tc[i], 3'h2, ta[i]);
      check("decode", cmd, te[i]);
    end
    check("auto pre", array_auto_pre, 1'b1);
    check("wr addr", {array_chop, array_bank, array_addr}, {1'b0, 3'h2, 14'h0408});
    burst(14'h0010, 8'h00, 8, 0, 1'b1);
    check("rd beat", array_beat, 3'h7);
    check("rd bank", {array_auto_pre, array_bank}, 4'h7);
    ctl.send(5'h10, 3'h0, 14'h0001);
    ctl.send(5'h10, 3'h3, 14'h0004);
    check("mpr on", mpr_mode, 1'b1);
    burst(14'h17F8, 8'hAA, 8, 0, 1'b0);
    check("rda plain", array_auto_pre, 1'b0);
    burst(14'h0000, 8'hAA, 4, 0, 1'b0);
    burst(14'h0004, 8'hAA, 4, 4, 1'b0);
    ctl.send(5'h10, 3'h3, 14'h0000);
    ctl.send(5'h10, 3'h3, 14'h0005);
    burst(14'h1000, 8'h00, 8, 0, 1'b0);
    ctl.send(5'h10, 3'h3, 14'h0003);
    ctl.send(5'h10, 3'h0, 14'h0002);
    ctl.send(5'h10, 3'h3, 14'h0006);
    burst(14'h1000, 8'h00, 4, 0, 1'b0);
    ctl.send(5'h10, 3'h3, 14'h0003);
    check("mpr off", mpr_mode, 1'b0);
    burst(14'h1000, 8'h00, 4, 0, 1'b1);
    check("rd chop", {array_chop, array_beat}, 4'hB);
    ctl.send(5'h07, 3'h0, 14'h0000);
    check("pd entry", {cmd, power_down}, {cmd_pd_entry, 1'b1});
    ctl.send(5'h17, 3'h0, 14'h0000);
    check("pd exit", {cmd, power_down}, {cmd_pd_exit, 1'b0});
    ctl.send(5'h01, 3'h0, 14'h0000);
    check("sr entry", {cmd, self_refresh}, {cmd_sr_entry, 1'b1});
    ctl.send(5'h1F, 3'h0, 14'h0000);
    check("sr exit", {cmd, self_refresh}, {cmd_sr_exit, 1'b0});
    end_of_test();
  end
endmodule : tb_top
